// ===== logic/otd_trace.sv
// Purpose : bus comparators, trigger logic and 8-word capture FIFO
// Assumes : cpu bus signals are synchronous to pclk
// Notes   : registers reached over APB, ready in the first access cycle
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns

// Overview of operation
// R1 - two 16-bit comparators A and B, each with own read/write qualify enable
// R2 - opcode tracking: match only counts when matched opcode actually executes
// R3 - comparators give greater-equal and less-equal for inside/outside range
// R4 - no comparator match during background controller accesses
// R5 - A compares address; B compares address or data byte per mode
// R6 - full mode B uses write data if A qualify on and value write
// R7 - trigger requests breakpoint, stores data, starts or stops flow capture
// R8 - eight-entry FIFO, read out in store order
// R9 - count tracks valid words; manual halt before full shifts one extra place
// R10 - address modes: read high byte then low; low read shifts FIFO
// R11 - event modes store 8-bit data; each low read shifts FIFO
// R12 - flow address at start trigger and next two bus cycles not stored
// R13 - end trace: flow event at trigger stored as last entry
// R14 - unarmed low read pushes last fetched opcode address
// R15 - profiling host discards first eight values, reads at intervals
// R16 - taken conditional branch stores its own opcode address
// R17 - branch-always and branch-never store nothing
// R18 - indexed indirect jump or call stores run-time destination
// R19 - interrupt entry and returns store the destination address
// R20 - control and status registers reached through the register window
// R21 - writing arm 1 sets armed, clears match flags and count
// R22 - begin trace ends when full; end trace ends on trigger
// R23 - count increments per stored word, saturates at eight, drops on low read
// R24 - writing arm 0 stops capture, clears armed, keeps FIFO contents
module otd_trace #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // cpu side
    input  wire otd_pkg::otd_bus_t   bus,
    input  wire otd_pkg::otd_exec_t  exec,
    input  wire otd_pkg::otd_cofev_t cof,
    // breakpoint request
    output logic                   brk_req,
    output logic                   brk_tag
);
    import otd_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [11:0]  ctrl_q;
    logic [15:0]  cmpa_q;
    logic [15:0]  cmpb_q;
    logic         armed_q;
    logic         ahit_q;
    logic         bhit_q;
    logic         started_q;
    logic         a_seen_q;
    logic [1:0]   blank_q;
    logic [3:0]   fill_q;
    logic [15:0]  fetch_q;
    logic [15:0]  mem_q [DEPTH];
    logic         pready_q;
    logic [31:0]  prdata_q;
    logic         pslverr_q;
    logic         brk_q;
    logic         tag_q;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic rw_ok(input logic en, input logic want,
                                   input logic rd);
        rw_ok = !en || (want == rd);
    endfunction

    function automatic logic [3:0] fill_next(input logic [3:0] c,
                                             input logic inc,
                                             input logic dec);
        logic [3:0] n;
        n = c;
        if (inc && !dec && c < OTD_FIFO_FULL)
            n = c + 4'h1;
        else if (dec && !inc && c != 4'h0)
            n = c - 4'h1;
        fill_next = n;
    endfunction

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic setup;
    logic done;
    logic wr_ctrl;
    logic pop;
    logic arm_start;
    logic arm_stop;
    logic mapped;

    assign setup     = psel && !penable;
    assign done      = psel && penable && pready_q;
    assign wr_ctrl   = done && pwrite && paddr == OTD_OFS_CTRL;
    assign pop       = done && !pwrite && paddr == OTD_OFS_FLOW; // [R10] [R11]
    assign arm_start = wr_ctrl && pwdata[OTD_C_ARM];             // [R21]
    assign arm_stop  = wr_ctrl && !pwdata[OTD_C_ARM];            // [R24]
    assign mapped    = paddr inside {OTD_OFS_CTRL, OTD_OFS_CMPA, OTD_OFS_CMPB,
                                     OTD_OFS_STAT, OTD_OFS_FHIGH, OTD_OFS_FLOW};

    // ---------------------------------------------------------------
    // comparators
    // ---------------------------------------------------------------
    otd_trg_t    mode;
    logic        trk;
    logic        ev_mode;
    logic        begin_mode;
    logic [15:0] sa;
    logic        va;
    logic        rwv;
    logic [7:0]  dbyte;
    logic        a_eq;
    logic        b_eq;
    logic        b_dat;
    logic        a_ge;
    logic        b_le;
    logic        trig;

    assign mode       = otd_trg_t'(ctrl_q[OTD_C_TRG +: 4]);
    assign trk        = ctrl_q[OTD_C_TRK];
    assign ev_mode    = mode == TRG_EV_B || mode == TRG_A_THEN_EV_B;
    // event modes are always begin type
    assign begin_mode = ctrl_q[OTD_C_BEGIN] || ev_mode;

    // tracking compares the executed opcode, so prefetched then flushed
    // opcodes never match
    assign sa  = trk ? exec.addr : bus.addr;                     // [R2]
    assign va  = (trk ? exec.vld : bus.cyc) && !bus.bgnd;        // [R2] [R4]
    assign rwv = trk ? 1'b1 : bus.rd;

    // write data only when A qualifies on a write cycle
    assign dbyte = (ctrl_q[OTD_C_A_RWQ] && !ctrl_q[OTD_C_A_RWV])
                 ? bus.wdata : bus.rdata;                        // [R6]

    assign a_eq  = va && sa == cmpa_q
                 && rw_ok(ctrl_q[OTD_C_A_RWQ], ctrl_q[OTD_C_A_RWV], rwv); // [R1] [R5]
    assign b_eq  = va && sa == cmpb_q
                 && rw_ok(ctrl_q[OTD_C_RWBEN], ctrl_q[OTD_C_RWB], rwv); // [R1]
    assign b_dat = bus.cyc && !bus.bgnd && dbyte == cmpb_q[7:0]; // [R5] [R4]
    assign a_ge  = va && sa >= cmpa_q;                           // [R3]
    assign b_le  = va && sa <= cmpb_q;                           // [R3]

    always_comb begin
        unique case (mode)
            TRG_A_ONLY:      trig = a_eq;
            TRG_A_OR_B:      trig = a_eq || b_eq;
            TRG_A_THEN_B:    trig = b_eq && a_seen_q;
            TRG_A_AND_BD:    trig = a_eq && b_dat;
            TRG_A_NOT_BD:    trig = a_eq && !b_dat;
            TRG_EV_B:        trig = b_eq;
            TRG_A_THEN_EV_B: trig = b_eq && a_seen_q;
            TRG_INSIDE:      trig = a_ge && b_le;               // [R3]
            TRG_OUTSIDE:     trig = va && !(a_ge && b_le);      // [R3]
            default:         trig = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // capture decisions
    // ---------------------------------------------------------------
    logic        cof_ok;
    logic [15:0] cof_addr;
    logic        push_cof;
    logic        push_ev;
    logic        push;
    logic [15:0] push_val;
    logic        end_hit;
    logic        halt_shift;
    logic        start_trig;

    assign cof_ok   = cof.vld && cof.kind != COF_UNCOND;         // [R17]
    assign cof_addr = (cof.kind == COF_COND)
                    ? cof.src                                    // [R16]
                    : cof.dst;                                   // [R18] [R19]

    // the trigger cycle itself is blanked by started_q still being low;
    // a disarm write stops capture in its own cycle
    assign push_cof = armed_q && !arm_stop && !ev_mode && cof_ok   // [R24]
                    && (!begin_mode || (started_q && blank_q == 2'h0)); // [R12] [R13]
    assign push_ev  = armed_q && !arm_stop && ev_mode && trig;   // [R7] [R11]
    assign push     = push_cof || push_ev;
    assign push_val = push_ev ? {8'h00, bus.rd ? bus.rdata : bus.wdata}
                              : cof_addr;

    assign start_trig = armed_q && begin_mode && !ev_mode
                      && !started_q && trig;                     // [R7]
    assign end_hit    = armed_q && !begin_mode && trig;          // [R22]
    // manual stop before full leaves the data one place off
    assign halt_shift = arm_stop && armed_q && fill_q < OTD_FIFO_FULL; // [R9]

    // ---------------------------------------------------------------
    // registers written by software
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= OTD_CTRL_RST;
            cmpa_q <= OTD_CMP_RST;
            cmpb_q <= OTD_CMP_RST;
        end else if (done && pwrite) begin
            if (paddr == OTD_OFS_CTRL)
                ctrl_q <= pwdata[OTD_CTRL_W-1:0];
            if (paddr == OTD_OFS_CMPA)
                cmpa_q <= pwdata[15:0];
            if (paddr == OTD_OFS_CMPB)
                cmpb_q <= pwdata[15:0];
        end
    end

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q   <= 1'b0;
            started_q <= 1'b0;
            a_seen_q  <= 1'b0;
        end else if (arm_start) begin
            armed_q   <= 1'b1;                                   // [R21]
            started_q <= 1'b0;
            a_seen_q  <= 1'b0;
        end else begin
            if (arm_stop || end_hit)
                armed_q <= 1'b0;                                 // [R24] [R22]
            else if (armed_q && begin_mode && push
                     && !pop && fill_q == OTD_FIFO_FULL - 4'h1)
                armed_q <= 1'b0;                                 // [R22]
            if (start_trig)
                started_q <= 1'b1;
            if (armed_q && a_eq)
                a_seen_q <= 1'b1;
        end
    end

    // blank window: trigger cycle plus the next two bus cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            blank_q <= 2'h0;
        else if (start_trig)
            blank_q <= OTD_BLANK_CYC;                            // [R12]
        else if (bus.cyc && blank_q != 2'h0)
            blank_q <= blank_q - 2'h1;
    end

    // match flags: a match in the arming cycle still sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ahit_q <= 1'b0;
            bhit_q <= 1'b0;
        end else begin
            if (armed_q && a_eq)
                ahit_q <= 1'b1;
            else if (arm_start)
                ahit_q <= 1'b0;                                  // [R21]
            if (armed_q && b_eq)
                bhit_q <= 1'b1;
            else if (arm_start)
                bhit_q <= 1'b0;                                  // [R21]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fetch_q <= 16'h0000;
        else if (bus.cyc && bus.fetch && !bus.bgnd)
            fetch_q <= bus.addr;
    end

    // ---------------------------------------------------------------
    // capture fifo: shifts toward entry 0, new words enter at the top
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= 16'h0000;
        end else if (push || pop || halt_shift) begin
            for (int i = 0; i < DEPTH - 1; i++)
                mem_q[i] <= mem_q[i+1];                          // [R8]
            if (push)
                mem_q[DEPTH-1] <= push_val;
            else if (pop && !armed_q)
                mem_q[DEPTH-1] <= fetch_q;                       // [R14]
            else
                mem_q[DEPTH-1] <= 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fill_q <= 4'h0;
        else if (arm_start)
            fill_q <= 4'h0;                                      // [R21]
        else
            fill_q <= fill_next(fill_q, push, pop);              // [R23] [R9]
    end

    // ---------------------------------------------------------------
    // breakpoint request
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_q <= 1'b0;
            tag_q <= 1'b0;
        end else begin
            brk_q <= armed_q && ctrl_q[OTD_C_BRKEN] && trig;     // [R7]
            tag_q <= trk;
        end
    end

    // ---------------------------------------------------------------
    // apb answer: data latched in setup, ready in access
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !pwrite) begin
                unique case (paddr)                              // [R20]
                    OTD_OFS_CTRL:  prdata_q <= {20'h0, ctrl_q};
                    OTD_OFS_CMPA:  prdata_q <= {16'h0, cmpa_q};
                    OTD_OFS_CMPB:  prdata_q <= {16'h0, cmpb_q};
                    OTD_OFS_STAT:  prdata_q <= {24'h0, fill_q, 1'b0,
                                                bhit_q, ahit_q, armed_q};
                    OTD_OFS_FHIGH: prdata_q <= {24'h0, mem_q[0][15:8]};
                    OTD_OFS_FLOW:  prdata_q <= {24'h0, mem_q[0][7:0]};
                    default:       prdata_q <= 32'h0000_0000;
                endcase
            end else if (setup) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign brk_req = brk_q;
    assign brk_tag = tag_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_arm_clears_run: assert property (arm_start |=> armed_q && fill_q == 4'h0) // [R21]
        else $error("arm write did not start a clean run");
    a_bgnd_no_match: assert property (bus.bgnd |-> !a_eq && !b_eq && !b_dat) // [R4]
        else $error("comparator matched a background access");
    a_fill_bounded: assert property (fill_q <= OTD_FIFO_FULL) // [R23]
        else $error("fifo count above eight");
    a_disarm_keeps: assert property (arm_stop && !halt_shift && !pop
                                     |=> !armed_q && mem_q[0] == $past(mem_q[0])) // [R24]
        else $error("disarm lost fifo contents or stayed armed");
    a_halt_one_shift: assert property (halt_shift |=> mem_q[0] == $past(mem_q[1])) // [R9]
        else $error("manual halt did not shift by one");
    a_begin_ends_full: assert property (armed_q && begin_mode && push
                                        && !pop && fill_q == 4'h7 && !arm_start
                                        |=> !armed_q && fill_q == OTD_FIFO_FULL) // [R22]
        else $error("begin run did not end at full");
    a_end_on_trig: assert property (end_hit && !arm_start |=> !armed_q) // [R22]
        else $error("end run kept going after trigger");
    a_uncond_skipped: assert property (cof.vld && cof.kind == COF_UNCOND |-> !push_cof) // [R17]
        else $error("unconditional branch stored");
    a_cond_source: assert property (push_cof && cof.kind == COF_COND && !pop
                                    |=> mem_q[DEPTH-1] == $past(cof.src)) // [R16]
        else $error("taken branch did not store its source");
    a_dest_stored: assert property (push_cof && cof.kind != COF_COND
                                    |=> mem_q[DEPTH-1] == $past(cof.dst)) // [R18] [R19]
        else $error("destination address not stored");
    a_blank_window: assert property (start_trig |-> !push_cof ##1 blank_q == 2'h2) // [R12]
        else $error("start trigger blank window wrong");
    a_low_read_shift: assert property (pop && !push |=> mem_q[0] == $past(mem_q[1])) // [R10]
        else $error("low byte read did not shift fifo");
    a_profile_push: assert property (pop && !armed_q
                                     |=> mem_q[DEPTH-1] == $past(fetch_q)) // [R14]
        else $error("profiling read did not capture fetch address");
    a_brk_follows: assert property (armed_q && ctrl_q[OTD_C_BRKEN] && trig |=> brk_req) // [R7]
        else $error("trigger did not request breakpoint");
    a_ready_one: assert property (setup |=> pready ##1 !pready) // [R20]
        else $error("apb ready not a single access cycle");

    c_begin_full: cover property (armed_q && begin_mode ##1 !armed_q && fill_q == 4'h8);
    c_end_trig:   cover property (end_hit && push_cof);
    c_manual_halt: cover property (halt_shift);
    c_profile:    cover property (pop && !armed_q);

endmodule // otd_trace

// ===== pkg/otd_pkg.sv
// Purpose : shared constants and types for the on-chip bus trace unit
// Assumes : APB register window, 32-bit data, one word per register
// Notes   : register offsets are byte addresses
package otd_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OTD_OFS_CTRL  = 8'h00;
    localparam logic [7:0] OTD_OFS_CMPA  = 8'h04;
    localparam logic [7:0] OTD_OFS_CMPB  = 8'h08;
    localparam logic [7:0] OTD_OFS_STAT  = 8'h0C;
    localparam logic [7:0] OTD_OFS_FHIGH = 8'h10;
    localparam logic [7:0] OTD_OFS_FLOW  = 8'h14;

    // control field positions
    localparam int OTD_C_ARM   = 0;
    localparam int OTD_C_BRKEN = 1;
    localparam int OTD_C_TRK   = 2;
    localparam int OTD_C_BEGIN = 3;
    localparam int OTD_C_A_RWQ = 4;
    localparam int OTD_C_A_RWV = 5;
    localparam int OTD_C_RWBEN = 6;
    localparam int OTD_C_RWB   = 7;
    localparam int OTD_C_TRG   = 8;
    localparam int OTD_CTRL_W  = 12;

    // status field positions
    localparam int OTD_S_ARMED = 0;
    localparam int OTD_S_AHIT  = 1;
    localparam int OTD_S_BHIT  = 2;
    localparam int OTD_S_FILL  = 4;

    // reset values and counts
    localparam logic [11:0] OTD_CTRL_RST  = 12'h000;
    localparam logic [15:0] OTD_CMP_RST   = 16'h0000;
    localparam logic [3:0]  OTD_FIFO_FULL = 4'h8;
    localparam logic [1:0]  OTD_BLANK_CYC = 2'h2;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        TRG_A_ONLY, TRG_A_OR_B, TRG_A_THEN_B, TRG_A_AND_BD,
        TRG_A_NOT_BD, TRG_EV_B, TRG_A_THEN_EV_B, TRG_INSIDE, TRG_OUTSIDE
    } otd_trg_t;

    typedef enum logic [2:0] {
        COF_COND, COF_UNCOND, COF_IDX_JUMP, COF_INT, COF_RET
    } otd_cof_t;

    typedef struct packed {
        logic        cyc;    // bus cycle valid
        logic        rd;     // 1 read, 0 write
        logic        bgnd;   // access made for the background controller
        logic        fetch;  // opcode fetch
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
    } otd_bus_t;

    typedef struct packed {
        logic        vld;
        logic [15:0] addr;
    } otd_exec_t;

    typedef struct packed {
        logic        vld;
        otd_cof_t    kind;
        logic [15:0] src;
        logic [15:0] dst;
    } otd_cofev_t;

endpackage

// ===== bench/otd_cpu_model.sv
// Purpose : cpu-side model for the trace unit bench
// Assumes : drive is called just after a rising edge
// Notes   : released lines go inverted so stale values never match
`timescale 1ns/1ns
module otd_cpu_model (
    // clock
    input  wire logic           pclk,
    // cpu buses
    output otd_pkg::otd_bus_t   bus,
    output otd_pkg::otd_exec_t  exec,
    output otd_pkg::otd_cofev_t cof
);
    import otd_pkg::*;
    initial begin
        bus  = '0;
        exec = '0;
        cof  = '0;
    end
    // one bus cycle with an optional flow event, then release
    task automatic drive(otd_bus_t b, otd_cofev_t c);
        @(posedge pclk);
        bus <= b;
        cof <= c;
        @(posedge pclk);
        bus <= otd_bus_t'({1'b0, ~b[34:0]});
        cof <= otd_cofev_t'({1'b0, ~c[34:0]});
    endtask
endmodule // otd_cpu_model

// ===== bench/onchip_bus_trace_debug_tb.sv
// Purpose : self-checking bench for the trace unit
// Assumes : cpu_u drives the cpu buses
// Notes   : random values from a fixed xorshift seed
`timescale 1ns/1ns
module onchip_bus_trace_debug_tb;
    import otd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, brk_req, brk_tag, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, seed;
    otd_bus_t    bus;
    otd_exec_t   exec;
    otd_cofev_t  cof;
    logic [15:0] q[$];
    int          bad_count, checks;

    otd_trace #(.DEPTH(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus(bus), .exec(exec),
        .cof(cof), .brk_req(brk_req), .brk_tag(brk_tag));
    otd_cpu_model cpu_u (.pclk(pclk), .bus(bus), .exec(exec), .cof(cof));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ----
    // helpers
    // ----
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] cof_exp(otd_cofev_t c);
        return (c.kind == COF_COND) ? c.src : c.dst;
    endfunction

    function automatic otd_bus_t mb(logic [15:0] a, logic bg, logic [7:0] d);
        return '{1'b1, 1'b0, bg, 1'b0, a, d, d};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int k;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_word(logic [15:0] e);
        apb(1'b0, OTD_OFS_FHIGH, '0);
        chk(rdat, {24'h0, e[15:8]});
        apb(1'b0, OTD_OFS_FLOW, '0);
        chk(rdat, {24'h0, e[7:0]});
    endtask

    // random flow events until n words are expected
    task automatic push_cofs(int n);
        otd_cofev_t c;
        repeat (40) if (q.size() < n) begin
            c = '{1'b1, otd_cof_t'(xs() % 5), 16'(xs()), 16'(xs())};
            if (c.kind != COF_UNCOND) q.push_back(cof_exp(c));
            cpu_u.drive('0, c);
        end
    endtask

    // ----
    // sequence
    // ----
    initial begin
        otd_cofev_t c;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h7A4D;
        bad_count = 0;
        checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat, 32'h0);
        apb(1'b0, 8'h18, '0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, OTD_OFS_CTRL, 32'hFF4);
        apb(1'b0, OTD_OFS_CTRL, '0);
        chk(rdat, 32'hFF4);
        chk({31'h0, brk_tag}, 32'h1);
        $display("test regs done");
        // end-type flow run with breakpoint
        apb(1'b1, OTD_OFS_CMPA, 32'hA55A);
        apb(1'b1, OTD_OFS_CTRL, 32'h003);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'hF7, 32'h01);
        push_cofs(9);
        cpu_u.drive(mb(16'hA55A, 1'b1, 8'h00), '0);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'h3, 32'h1);
        c = '{1'b1, COF_RET, 16'h0, 16'(xs())};
        q.push_back(c.dst);
        cpu_u.drive(mb(16'hA55A, 1'b0, 8'h00), c);
        @(posedge pclk);
        chk({31'h0, brk_req}, 32'h1);
        @(posedge pclk);
        chk({31'h0, brk_req}, 32'h0);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'hF3, 32'h82);
        while (q.size() > 8) void'(q.pop_front());
        repeat (8) rd_word(q.pop_front());
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'hF0, 32'h0);
        $display("test flow run done");
        // event-only run stores write data
        apb(1'b1, OTD_OFS_CMPB, 32'h2468);
        apb(1'b1, OTD_OFS_CTRL, 32'h501);
        repeat (8) begin
            q.push_back(16'(xs() & 32'hFF));
            cpu_u.drive(mb(16'h2468, 1'b0, q[$][7:0]), '0);
        end
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'hF1, 32'h80);
        repeat (8) rd_word(q.pop_front());
        $display("test event run done");
        // manual halt before full
        apb(1'b1, OTD_OFS_CTRL, 32'h901);
        push_cofs(3);
        apb(1'b1, OTD_OFS_CTRL, 32'h900);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'hF1, 32'h30);
        repeat (4) apb(1'b0, OTD_OFS_FLOW, '0);
        repeat (3) rd_word(q.pop_front());
        $display("test manual halt done");
        // profiling while not armed
        cpu_u.drive('{1'b1, 1'b1, 1'b0, 1'b1, 16'h1357, 8'h0, 8'h0}, '0);
        repeat (8) apb(1'b0, OTD_OFS_FLOW, '0);
        rd_word(16'h1357);
        $display("test profiling done");
        // full mode, A qualified on writes: B data taken from the write bus
        apb(1'b1, OTD_OFS_CTRL, 32'h311);
        cpu_u.drive('{1'b1, 1'b0, 1'b0, 1'b0, 16'hA55A, 8'h97, 8'h68}, '0);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'h1, 32'h1);
        cpu_u.drive('{1'b1, 1'b0, 1'b0, 1'b0, 16'hA55A, 8'h68, 8'h97}, '0);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'h3, 32'h2);
        $display("test full mode done");
        // begin flow run: trigger cycle and two bus cycles after it blanked
        apb(1'b1, OTD_OFS_CTRL, 32'h009);
        c = '{1'b1, COF_COND, 16'(xs()), 16'(xs())};
        cpu_u.drive(mb(16'hA55A, 1'b0, 8'h00), c);
        repeat (2) cpu_u.drive(mb(16'h0000, 1'b0, 8'h00), c);
        push_cofs(8);
        apb(1'b0, OTD_OFS_STAT, '0);
        chk(rdat & 32'hF1, 32'h80);
        repeat (8) rd_word(q.pop_front());
        $display("test begin run done");
        report_and_stop();
    end
endmodule // onchip_bus_trace_debug_tb
